// ---- rtl/lsf_pkg.sv ----
// Function
// RQ1 - continue option ignores external fault line low
// RQ2 - all-off option: external low stops boost, sinks
// RQ3 - restart only after release, no pending fault
// RQ4 - external high never clears latched fault
// RQ5 - partial short during dimming low does nothing
// RQ6 - detect: pin above threshold, other string regulating
// RQ7 - after detection time disable string, pull line
// RQ8 - retry disabled string at each dimming high
// RQ9 - release line at second high after removal
// RQ10 - detection also needs another pin below reference
// RQ11 - all-off option latches; long low clears latch
// RQ12 - synchronise dimming and fault line inputs
`default_nettype none

package lsf_pkg;

    // ****************************************
    // sizes and timing
    // ****************************************
    localparam int NUM_STR = 4;
    localparam int CLK_PERIOD_NS = 25;
    localparam int DET_TIME_NS = 2000;
    localparam int DET_CYCLES = (DET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DET_CNT_W = 7;
    localparam logic [DET_CNT_W-1:0] DET_LAST = DET_CNT_W'(DET_CYCLES - 1);
    localparam logic [DET_CNT_W-1:0] DET_CNT_RST = 7'h00;
    localparam int RST_TIME_US = 16000;
    localparam int RST_CYCLES_DEF = RST_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int RST_CNT_W = 20;
    localparam logic [RST_CNT_W-1:0] RST_CNT_RST = 20'h00000;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [1:0] DIM_SYNC_RST = 2'h0;
    localparam logic [1:0] LINE_SYNC_RST = 2'h3;
    localparam logic [2:0] OE_HIST_RST = 3'h0;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        LSF_PS_RUN = 2'b00,
        LSF_PS_OFF = 2'b01,
        LSF_PS_RETRY = 2'b11,
        LSF_PS_CLEAN = 2'b10
    } lsf_pstate_t;

    typedef struct packed {
        logic [NUM_STR-1:0] above_thr;
        logic [NUM_STR-1:0] below_ref;
        logic [NUM_STR-1:0] in_reg;
        logic [NUM_STR-1:0] used;
    } lsf_pins_t;

    typedef struct packed {
        logic [NUM_STR-1:0] sink_en;
        logic boost_en;
        logic disconnect_on;
    } lsf_drv_t;

endpackage : lsf_pkg

`default_nettype wire

// ---- rtl/lsf_psd.sv ----
`default_nettype none

module lsf_psd (
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic dim_hi_in,
    input wire logic dim_rise_in,
    input wire logic dim_fall_in,
    input wire logic cond_in,
    output logic enabled_out,
    output logic flagged_out,
    output logic det_done_out
);
    import lsf_pkg::*;

    lsf_pstate_t state_ff;
    lsf_pstate_t nxt_state;
    logic [DET_CNT_W-1:0] cnt_ff;
    logic counting;

    // qualify only while dimming is high and the sink runs
    assign counting = dim_hi_in && cond_in && (state_ff != LSF_PS_OFF); // see RQ5
    assign det_done_out = counting && (cnt_ff == DET_LAST); // see RQ7
    assign enabled_out = (state_ff != LSF_PS_OFF);
    assign flagged_out = (state_ff != LSF_PS_RUN);

    // detection interval counter
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt_ff <= DET_CNT_RST;
        end else if (counting && !det_done_out) begin
            cnt_ff <= cnt_ff + 7'h01; // see RQ6
        end else begin
            cnt_ff <= DET_CNT_RST;
        end
    end

    // string fault sequence
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            LSF_PS_RUN: begin
                if (det_done_out) nxt_state = LSF_PS_OFF; // see RQ7
            end
            LSF_PS_OFF: begin
                if (dim_rise_in) nxt_state = LSF_PS_RETRY; // see RQ8
            end
            LSF_PS_RETRY: begin
                if (det_done_out) nxt_state = LSF_PS_OFF; // see RQ8
                else if (dim_fall_in) nxt_state = LSF_PS_CLEAN;
            end
            LSF_PS_CLEAN: begin
                if (det_done_out) nxt_state = LSF_PS_OFF;
                else if (dim_rise_in) nxt_state = LSF_PS_RUN; // see RQ9
            end
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_ff <= LSF_PS_RUN;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);

    // helper: run of qualifying cycles
    logic [DET_CNT_W-1:0] run_len_ff;
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            run_len_ff <= DET_CNT_RST;
        end else if (dim_hi_in && cond_in && enabled_out && !det_done_out) begin
            run_len_ff <= run_len_ff + 7'h01;
        end else begin
            run_len_ff <= DET_CNT_RST;
        end
    end

    a_dim_low_quiet: assert property (!dim_hi_in |-> !det_done_out) // see RQ5
        else $error("detection fired while dimming low");
    a_det_interval: assert property (det_done_out |-> run_len_ff == DET_LAST) // see RQ6
        else $error("detection interval wrong");
    a_det_disable: assert property (det_done_out |=> !enabled_out && flagged_out) // see RQ7
        else $error("string not disabled after detection");
    a_retry_rise: assert property (!enabled_out && dim_rise_in |=> enabled_out && flagged_out) // see RQ8
        else $error("no retry at dimming high");
    a_flag_second: assert property ($fell(flagged_out) |-> $past(dim_rise_in) && $past(state_ff) == LSF_PS_CLEAN) // see RQ9
        else $error("flag cleared at wrong phase");
    c_retry_fail: cover property (state_ff == LSF_PS_RETRY ##1 state_ff == LSF_PS_OFF);
    c_flag_clear: cover property (state_ff == LSF_PS_CLEAN ##1 state_ff == LSF_PS_RUN);

endmodule : lsf_psd

`default_nettype wire

// ---- rtl/lsf_supervisor.sv ----
`default_nettype none

module lsf_supervisor #(
    parameter int RST_CYCLES = lsf_pkg::RST_CYCLES_DEF
) (
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic enable_in,
    input wire logic dim_in,
    input wire logic all_off_mode_in,
    input wire logic int_fault_pending_in,
    input wire lsf_pkg::lsf_pins_t pins_in,
    input wire logic fault_line_in,
    output logic fault_line_out,
    output logic fault_line_oe_out,
    output lsf_pkg::lsf_drv_t drv_out,
    output logic latched_off_out
);
    import lsf_pkg::*;

    // ****************************************
    // input synchronisers
    // ****************************************
    logic [1:0] dim_sync_ff;
    logic [1:0] line_sync_ff;
    logic dim_d_ff;
    logic dim_s;
    logic line_s;
    logic dim_rise;
    logic dim_fall;

    // two-flop synchronisers for dimming and shared line
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            dim_sync_ff <= DIM_SYNC_RST;
            line_sync_ff <= LINE_SYNC_RST;
        end else begin
            dim_sync_ff <= {dim_sync_ff[0], dim_in}; // see RQ12
            line_sync_ff <= {line_sync_ff[0], fault_line_in}; // see RQ12
        end
    end

    // edge history on the synchronised dimming level
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            dim_d_ff <= 1'b0;
        end else begin
            dim_d_ff <= dim_s;
        end
    end

    assign dim_s = dim_sync_ff[1];
    assign line_s = line_sync_ff[1];
    assign dim_rise = dim_s && !dim_d_ff;
    assign dim_fall = !dim_s && dim_d_ff;

    // ****************************************
    // per-string partial short detection
    // ****************************************
    logic [NUM_STR-1:0] cond;
    logic [NUM_STR-1:0] str_en;
    logic [NUM_STR-1:0] str_flag;
    logic [NUM_STR-1:0] det_done;

    // pin high while another sink regulates and another pin is low
    function automatic logic [NUM_STR-1:0] short_cond(input lsf_pins_t p, input logic [NUM_STR-1:0] en);
        logic [NUM_STR-1:0] r;
        logic [NUM_STR-1:0] others;
        r = '0;
        for (int i = 0; i < NUM_STR; i++) begin
            others = ~(NUM_STR'(1) << i);
            r[i] = p.used[i] && p.above_thr[i]
                && |(p.in_reg & p.used & en & others) // see RQ6
                && |(p.below_ref & p.used & others); // see RQ10
        end
        return r;
    endfunction : short_cond

    assign cond = short_cond(pins_in, str_en);

    for (genvar g = 0; g < NUM_STR; g++) begin : g_str
        lsf_psd u_psd (
            .ref_clk_in(ref_clk_in),
            .nrst_in(nrst_in),
            .dim_hi_in(dim_s),
            .dim_rise_in(dim_rise),
            .dim_fall_in(dim_fall),
            .cond_in(cond[g]),
            .enabled_out(str_en[g]),
            .flagged_out(str_flag[g]),
            .det_done_out(det_done[g])
        );
    end

    // ****************************************
    // latch-off and its long-low reset timer
    // ****************************************
    logic [RST_CNT_W-1:0] low_cnt_ff;
    logic low_lvl;
    logic low_done;
    logic latch_off_ff;

    assign low_lvl = !enable_in || !dim_s;
    assign low_done = low_lvl && (low_cnt_ff == RST_CNT_W'(RST_CYCLES - 1));

    // counts a continuous low on enable or dimming
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            low_cnt_ff <= RST_CNT_RST;
        end else if (!low_lvl) begin
            low_cnt_ff <= RST_CNT_RST;
        end else if (!low_done) begin
            low_cnt_ff <= low_cnt_ff + 20'h00001; // see RQ11
        end
    end

    // latch on any detection in all-off option, set wins
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            latch_off_ff <= 1'b0;
        end else if (all_off_mode_in && |det_done) begin
            latch_off_ff <= 1'b1; // see RQ11
        end else if (low_done) begin
            latch_off_ff <= 1'b0; // see RQ4
        end
    end

    // ****************************************
    // external pull-down on the shared line
    // ****************************************
    logic [2:0] oe_hist_ff;
    logic own_drive;
    logic ext_low;
    logic ext_shut_ff;

    // own drive seen through the synchroniser for three cycles
    assign own_drive = fault_line_oe_out || |oe_hist_ff;
    assign ext_low = all_off_mode_in && !line_s && !own_drive; // see RQ1

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            oe_hist_ff <= OE_HIST_RST;
        end else begin
            oe_hist_ff <= {oe_hist_ff[1:0], fault_line_oe_out};
        end
    end

    // held until released and nothing internal pending, set wins
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ext_shut_ff <= 1'b0;
        end else if (ext_low) begin
            ext_shut_ff <= 1'b1; // see RQ2
        end else if (!int_fault_pending_in && !latch_off_ff) begin
            ext_shut_ff <= 1'b0; // see RQ3
        end
    end

    // ****************************************
    // output drive
    // ****************************************
    logic shut;
    logic oe_ff;
    lsf_drv_t drv_ff;

    assign shut = latch_off_ff || ext_shut_ff || ext_low;

    // registered sink, boost and disconnect enables
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            drv_ff <= '0;
        end else begin
            drv_ff.sink_en <= (enable_in && dim_s && !shut) ? (str_en & pins_in.used) : '0; // see RQ7
            drv_ff.boost_en <= enable_in && !shut; // see RQ2
            drv_ff.disconnect_on <= !latch_off_ff; // see RQ2
        end
    end

    // line pulled low while any string is flagged or latched
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            oe_ff <= 1'b0;
        end else begin
            oe_ff <= |str_flag || latch_off_ff; // see RQ9
        end
    end

    assign drv_out = drv_ff;
    assign fault_line_out = 1'b0;
    assign fault_line_oe_out = oe_ff;
    assign latched_off_out = latch_off_ff;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);

    a_cont_ignore: assert property (!all_off_mode_in && !$past(all_off_mode_in) ##1 !all_off_mode_in |-> !ext_shut_ff) // see RQ1
        else $error("line acted on in continue option");
    a_ext_stop: assert property (ext_low |=> !drv_out.boost_en && drv_out.sink_en == '0) // see RQ2
        else $error("external low did not stop boost and sinks");
    a_ext_disc_on: assert property (ext_low && !latch_off_ff |=> drv_out.disconnect_on) // see RQ2
        else $error("disconnect switch turned off on external low");
    a_restart_gate: assert property ($fell(ext_shut_ff) |-> !$past(ext_low) && !$past(int_fault_pending_in)) // see RQ3
        else $error("restart while fault pending");
    a_latch_hold: assert property (latch_off_ff && !low_done |=> latch_off_ff) // see RQ4
        else $error("latched fault cleared without long low");
    a_det_line: assert property (|det_done |=> ##1 fault_line_oe_out) // see RQ7
        else $error("line not pulled low after detection");
    a_all_off_latch: assert property (all_off_mode_in && |det_done |=> latched_off_out ##1 drv_out.sink_en == '0) // see RQ11
        else $error("all-off option did not latch");
    a_line_sync: assert property ($rose(ext_shut_ff) |-> $past(fault_line_in, 3) == 1'b0) // see RQ12
        else $error("shutdown not from synchronised line");
    c_ext_shut: cover property (ext_low ##[1:20] !ext_shut_ff);
    c_latch_clear: cover property (latch_off_ff ##1 !latch_off_ff);
    c_det: cover property (|det_done);

endmodule : lsf_supervisor

`default_nettype wire

// ---- verif/lsf_strings_model.sv ----
`default_nettype none

// ******************************
// led strings and shared fault line
// ******************************
module lsf_strings_model (
    input wire lsf_pkg::lsf_drv_t drv_in,
    input wire logic [lsf_pkg::NUM_STR-1:0] used_in,
    input wire logic [lsf_pkg::NUM_STR-1:0] short_in,
    input wire logic low_pin_ok_in,
    input wire logic dev_oe_in,
    input wire logic dev_data_in,
    input wire logic host_pull_in,
    input wire logic host_high_in,
    output lsf_pkg::lsf_pins_t pins_out,
    output logic line_out
);
    import lsf_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic [NUM_STR-1:0] lit;

    // strings carry current only while their sink is on
    assign lit = used_in & drv_in.sink_en;

    // pin flags: above threshold, below reference, in regulation, in use
    assign pins_out = {lit & short_in, (low_pin_ok_in ? (lit & ~short_in) : 4'h0), lit, used_in};

    // open-drain line with pull-up, host may pull or force high
    assign line_out = host_high_in ? 1'b1 : (dev_oe_in ? dev_data_in : ~host_pull_in);
endmodule : lsf_strings_model

`default_nettype wire

// ---- verif/test_lsf_supervisor.sv ----
`default_nettype none

`define CHK(g, e, m) begin cmp_count++; if ((g) !== (e)) begin n_errors++; $display("MISMATCH %0t %s", $time, m); end end

module test_lsf_supervisor;
    timeunit 1ns;
    timeprecision 1ps;
    import lsf_pkg::*;

    // ******************************
    // stimulus and wiring
    // ******************************
    localparam int RST_N = 50;
    logic clk = 1'b0;
    logic nrst = 1'b0, en = 1'b1, dim = 1'b0, all_off = 1'b0, pend = 1'b0;
    logic pull = 1'b0, high = 1'b0, low_ok = 1'b1;
    logic line, line_q, oe, latched;
    logic [3:0] short = 4'h0;
    lsf_pins_t pins;
    lsf_drv_t drv;
    int n_errors = 0, cmp_count = 0, cyc = 0;

    // 40 MHz clock
    initial begin
        forever #12.5 clk = ~clk;
    end

    lsf_supervisor #(.RST_CYCLES(RST_N)) dut (.ref_clk_in(clk), .nrst_in(nrst), .enable_in(en),
        .dim_in(dim), .all_off_mode_in(all_off), .int_fault_pending_in(pend), .pins_in(pins),
        .fault_line_in(line), .fault_line_out(line_q), .fault_line_oe_out(oe), .drv_out(drv),
        .latched_off_out(latched));

    lsf_strings_model strings (.drv_in(drv), .used_in(4'h3), .short_in(short), .low_pin_ok_in(low_ok),
        .dev_oe_in(oe), .dev_data_in(line_q), .host_pull_in(pull), .host_high_in(high),
        .pins_out(pins), .line_out(line));

    // ******************************
    // helpers
    // ******************************
    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask : w

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out

    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            $display("MISMATCH %0t run too long", $time);
            close_out();
        end
    end

    // ******************************
    // scenarios
    // ******************************
    task automatic t_reset();
        w(12);
        `CHK(drv, 6'h00, "outputs in reset")
        `CHK({oe, latched}, 2'h0, "line and latch in reset")
        nrst = 1'b1;
        w(2);
        `CHK(drv.disconnect_on, 1'b1, "disconnect after reset")
        $display("test reset done");
    endtask : t_reset

    task automatic t_run();
        dim = 1'b1;
        w(6);
        `CHK({drv.sink_en[1:0], drv.boost_en}, 3'h7, "sinks follow dim")
        pull = 1'b1;
        w(10);
        `CHK({drv.sink_en[1:0], drv.boost_en, drv.disconnect_on, oe}, 5'h1e, "ext low ignored")
        pull = 1'b0;
        en = 1'b0;
        w(3);
        `CHK(drv.boost_en, 1'b0, "enable low stops boost")
        en = 1'b1;
        dim = 1'b0;
        w(60);
        $display("test run done");
    endtask : t_run

    task automatic t_short_walk();
        short = 4'h2;
        low_ok = 1'b0;
        w(40);
        `CHK(oe, 1'b0, "short while dim low")
        dim = 1'b1;
        w(120);
        `CHK({drv.sink_en[1], oe}, 2'h2, "no detect without low pin")
        dim = 1'b0;
        low_ok = 1'b1;
        w(60);
        dim = 1'b1;
        w(70);
        `CHK({drv.sink_en[1], oe}, 2'h2, "before detect time")
        w(30);
        `CHK({drv.sink_en[1:0], oe}, 3'h3, "string off, line low")
        `CHK(line_q, 1'b0, "line data not low")
        dim = 1'b0;
        w(60);
        dim = 1'b1;
        w(40);
        `CHK({drv.sink_en[1], oe}, 2'h3, "retry")
        w(60);
        `CHK({drv.sink_en[1], oe}, 2'h1, "off again")
        dim = 1'b0;
        short = 4'h0;
        w(60);
        dim = 1'b1;
        w(110);
        `CHK({drv.sink_en[1], oe}, 2'h3, "resumed, line held")
        dim = 1'b0;
        w(60);
        `CHK(oe, 1'b1, "line held in low phase")
        dim = 1'b1;
        w(20);
        `CHK(oe, 1'b0, "line released")
        dim = 1'b0;
        w(60);
        $display("test short walk done");
    endtask : t_short_walk

    task automatic t_ext_low();
        all_off = 1'b1;
        dim = 1'b1;
        w(10);
        pull = 1'b1;
        w(4);
        `CHK({drv.sink_en[1:0], drv.boost_en, drv.disconnect_on}, 4'h1, "ext low shuts")
        pend = 1'b1;
        pull = 1'b0;
        w(10);
        `CHK(drv.boost_en, 1'b0, "held by pending fault")
        pend = 1'b0;
        w(4);
        `CHK({drv.sink_en[1:0], drv.boost_en}, 3'h7, "restart")
        dim = 1'b0;
        w(60);
        $display("test ext low done");
    endtask : t_ext_low

    task automatic t_latch();
        short = 4'h2;
        dim = 1'b1;
        w(100);
        `CHK({drv, latched, oe}, 8'h03, "latched off")
        high = 1'b1;
        w(20);
        `CHK({latched, drv.boost_en}, 2'h2, "ext high keeps latch")
        high = 1'b0;
        short = 4'h0;
        dim = 1'b0;
        w(45);
        `CHK(latched, 1'b1, "latch before reset time")
        dim = 1'b1;
        w(3);
        dim = 1'b0;
        w(45);
        `CHK(latched, 1'b1, "reset count restarted")
        w(15);
        `CHK(latched, 1'b0, "latch cleared")
        $display("test latch done");
    endtask : t_latch

    // main sequence
    initial begin
        t_reset();
        t_run();
        t_short_walk();
        t_ext_low();
        t_latch();
        close_out();
    end
endmodule : test_lsf_supervisor

`default_nettype wire
